// file: src/ucdb_pkg.sv
// Package with register addresses, field positions, reset values and timing constants.
package ucdb_pkg;
  // Register addresses on the special function register port.
  localparam logic [7:0] ADDR_CONTROL = 8'h98;
  localparam logic [7:0] ADDR_DATA = 8'h99;
  // Extra registers: clock select and prescale code at the baud address, timer reload in its own register.
  localparam logic [7:0] ADDR_BAUD = 8'h9A;
  localparam logic [7:0] ADDR_RELOAD = 8'h9B;
  // Control register fields.
  localparam int BIT_MODE = 7;
  localparam int BIT_UNUSED = 6;
  localparam int BIT_MCE = 5;
  localparam int BIT_REN = 4;
  localparam int BIT_TB8 = 3;
  localparam int BIT_RB8 = 2;
  localparam int BIT_TXDONE = 1;
  localparam int BIT_RXDONE = 0;
  localparam logic [7:0] CONTROL_RESET = 8'h40;
  localparam logic [7:0] DATA_RESET = 8'h00;
  // Baud register fields.
  localparam int BIT_T1M = 2;
  localparam logic [1:0] PRESCALE_DIV12 = 2'b00;
  localparam logic [1:0] PRESCALE_DIV4 = 2'b01;
  localparam logic [1:0] PRESCALE_DIV48 = 2'b10;
  localparam logic [5:0] DIV12 = 6'd12;
  localparam logic [5:0] DIV4 = 6'd4;
  localparam logic [5:0] DIV48 = 6'd48;
  localparam logic [7:0] RELOAD_RESET = 8'h00;
  localparam logic [2:0] BAUD_RESET = 3'b000;
  // Eight-bit timer overflows twice per bit time.
  localparam logic [1:0] OVF_PER_BIT = 2'd2;
  localparam logic [1:0] OVF_HALF_BIT = 2'd1;
  localparam logic [3:0] DATA_BITS_8 = 4'd8;
  localparam logic [3:0] DATA_BITS_9 = 4'd9;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_WIDTH = 8;
  typedef enum logic [1:0] {
    UCDB_IDLE = 2'b00,
    UCDB_START = 2'b01,
    UCDB_DATA = 2'b10,
    UCDB_STOP = 2'b11
  } ucdb_phase_t;
endpackage

// file: src/ucdb_fifo.sv
// Parameterised synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module ucdb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Fill side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } ucdb_fifo_state_t;
  ucdb_fifo_state_t st_reg, st_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic full;
  logic empty;
  assign empty = st_reg.wr == st_reg.rd;
  assign full = (st_reg.wr[AW] != st_reg.rd[AW]) && (st_reg.wr[AW-1:0] == st_reg.rd[AW-1:0]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[st_reg.rd[AW-1:0]];
  always_comb begin
    st_next = st_reg;
    if (in_valid && !full) begin
      st_next.wr = st_reg.wr + 1'b1;
    end
    if (out_ready && !empty) begin
      st_next.rd = st_reg.rd + 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
    if (in_valid && !full) begin
      mem[st_reg.wr[AW-1:0]] <= in_data;
    end
  end
endmodule

// file: src/ucdb_uart.sv
// UART control register, data buffer, baud timing, transmitter and receiver.
//
// Overview of operation
// [RULE1] Received bytes are latched only while the receive enable bit is one.
// [RULE2] Nine-bit mode sends the ninth transmit bit; eight-bit mode ignores it.
// [RULE3] Ninth receive bit takes stop bit in eight-bit mode, ninth bit otherwise.
// [RULE4] Transmit done sets after bit eight, or at stop start in nine-bit mode.
// [RULE5] Transmit done raises the interrupt when enabled; only software clears it.
// [RULE6] Receive done sets at stop sampling, raises interrupt, software clears it.
// [RULE7] Writing the data buffer loads the transmitter and starts sending.
// [RULE8] Reading the data buffer returns the separate receive latch.
// [RULE9] Bit time equals the divide factor in system clocks from the reload.
// [RULE10] Clock select one counts system clock; else prescale 12, 4 or 48.
// [RULE11] Mode bit zero selects eight data bits, one selects nine.
// [RULE12] Nine-bit mode with multiprocessor enable flags only ninth-bit-one frames.
// [RULE13] Frame is low start, data least significant first, high stop.
`timescale 1ns/1ps
module ucdb_uart (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Special function register port.
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  // Interrupt enable from the core and request back to it.
  input wire logic serial_int_enable,
  output logic serial_int_req,
  // Serial lines.
  output logic tx_line,
  input wire logic rx_line,
  // Transmit buffer back-pressure.
  output logic tx_ready
);
  typedef struct packed {
    logic [7:0] control;
    logic [7:0] rx_latch;
    logic [7:0] reload;
    logic [2:0] baud;
    logic [5:0] pre_cnt;
    logic [7:0] timer;
    ucdb_pkg::ucdb_phase_t tx_ph;
    logic [1:0] tx_ovf;
    logic [3:0] tx_idx;
    logic [8:0] tx_sh;
    logic tx_out;
    ucdb_pkg::ucdb_phase_t rx_ph;
    logic [1:0] rx_ovf;
    logic [3:0] rx_idx;
    logic [8:0] rx_sh;
    logic [7:0] rdata;
  } ucdb_state_t;
  ucdb_state_t s_reg, s_next;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit buffer: writes queue here so up to eight back-to-back writes are not lost; writes while it is full are dropped.
  logic wr_data;
  logic f_valid;
  logic f_pop;
  logic [7:0] f_data;
  assign wr_data = sfr_wr && sfr_addr == ucdb_pkg::ADDR_DATA;
  ucdb_fifo #(.WIDTH(ucdb_pkg::FIFO_WIDTH), .DEPTH(ucdb_pkg::FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(wr_data),
    .in_ready(tx_ready),
    .in_data(sfr_wdata),
    .out_valid(f_valid),
    .out_ready(f_pop),
    .out_data(f_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Baud timer tick.
  logic [5:0] pre_div;
  logic tick_en;
  logic ovf;
  logic nine;
  always_comb begin
    case (s_reg.baud[1:0])
      ucdb_pkg::PRESCALE_DIV4: pre_div = ucdb_pkg::DIV4;
      ucdb_pkg::PRESCALE_DIV48: pre_div = ucdb_pkg::DIV48;
      default: pre_div = ucdb_pkg::DIV12;
    endcase
  end
  // A prescale change can leave the count above the new limit, so compare with >= to avoid a wrap.
  assign tick_en = s_reg.baud[ucdb_pkg::BIT_T1M] || s_reg.pre_cnt >= pre_div - 6'd1; // RULE10
  assign ovf = tick_en && s_reg.timer == 8'hFF; // RULE9
  // Frames start on an overflow so that the start bit lasts a full bit time, not a fraction.
  assign f_pop = s_reg.tx_ph == ucdb_pkg::UCDB_IDLE && ovf; // RULE7
  assign nine = s_reg.control[ucdb_pkg::BIT_MODE]; // RULE11
  assign serial_int_req = serial_int_enable &&
    (s_reg.control[ucdb_pkg::BIT_TXDONE] || s_reg.control[ucdb_pkg::BIT_RXDONE]); // RULE5 RULE6
  assign tx_line = s_reg.tx_out;
  assign sfr_rdata = s_reg.rdata;

  always_comb begin
    logic set_tx;
    logic set_rx;
    logic [3:0] nbits;
    logic stop_v;
    set_tx = 1'b0;
    set_rx = 1'b0;
    stop_v = 1'b0;
    s_next = s_reg;
    nbits = nine ? ucdb_pkg::DATA_BITS_9 : ucdb_pkg::DATA_BITS_8; // RULE11
    // Prescaler and reloading eight-bit timer.
    if (tick_en) begin
      s_next.pre_cnt = '0;
      s_next.timer = (s_reg.timer == 8'hFF) ? s_reg.reload : s_reg.timer + 8'd1; // RULE9
    end else begin
      s_next.pre_cnt = s_reg.pre_cnt + 6'd1;
    end
    // Transmitter.
    case (s_reg.tx_ph)
      ucdb_pkg::UCDB_IDLE: begin
        s_next.tx_out = 1'b1;
        if (f_valid && ovf) begin
          s_next.tx_sh = {s_reg.control[ucdb_pkg::BIT_TB8] & nine, f_data}; // RULE2 RULE7
          s_next.tx_ph = ucdb_pkg::UCDB_START;
          s_next.tx_ovf = '0;
          s_next.tx_out = 1'b0; // RULE13
        end
      end
      ucdb_pkg::UCDB_START: begin
        if (ovf) begin
          s_next.tx_ovf = s_reg.tx_ovf + 2'd1;
          if (s_reg.tx_ovf == ucdb_pkg::OVF_PER_BIT - 2'd1) begin
            s_next.tx_ovf = '0;
            s_next.tx_ph = ucdb_pkg::UCDB_DATA;
            s_next.tx_idx = '0;
            s_next.tx_out = s_reg.tx_sh[0]; // RULE13
          end
        end
      end
      ucdb_pkg::UCDB_DATA: begin
        if (ovf) begin
          s_next.tx_ovf = s_reg.tx_ovf + 2'd1;
          if (s_reg.tx_ovf == ucdb_pkg::OVF_PER_BIT - 2'd1) begin
            s_next.tx_ovf = '0;
            s_next.tx_idx = s_reg.tx_idx + 4'd1;
            s_next.tx_sh = {1'b0, s_reg.tx_sh[8:1]};
            s_next.tx_out = s_reg.tx_sh[1];
            if (!nine && s_reg.tx_idx == ucdb_pkg::DATA_BITS_8 - 4'd1) begin
              set_tx = 1'b1; // RULE4
            end
            if (s_reg.tx_idx == nbits - 4'd1) begin
              s_next.tx_ph = ucdb_pkg::UCDB_STOP;
              s_next.tx_out = 1'b1; // RULE13
              set_tx = set_tx | nine; // RULE4
            end
          end
        end
      end
      ucdb_pkg::UCDB_STOP: begin
        if (ovf) begin
          s_next.tx_ovf = s_reg.tx_ovf + 2'd1;
          if (s_reg.tx_ovf == ucdb_pkg::OVF_PER_BIT - 2'd1) begin
            s_next.tx_ovf = '0;
            s_next.tx_ph = ucdb_pkg::UCDB_IDLE;
          end
        end
      end
      default: s_next.tx_ph = ucdb_pkg::UCDB_IDLE;
    endcase
    // Receiver: samples at mid-bit, one overflow after each edge.
    case (s_reg.rx_ph)
      ucdb_pkg::UCDB_IDLE: begin
        if (!rx_line && s_reg.control[ucdb_pkg::BIT_REN]) begin // RULE1
          s_next.rx_ph = ucdb_pkg::UCDB_START;
          s_next.rx_ovf = '0;
        end
      end
      ucdb_pkg::UCDB_START: begin
        if (ovf) begin
          s_next.rx_ovf = s_reg.rx_ovf + 2'd1;
          if (s_reg.rx_ovf == ucdb_pkg::OVF_HALF_BIT - 2'd1) begin
            s_next.rx_ovf = '0;
            s_next.rx_idx = '0;
            s_next.rx_ph = rx_line ? ucdb_pkg::UCDB_IDLE : ucdb_pkg::UCDB_DATA; // RULE13
          end
        end
      end
      ucdb_pkg::UCDB_DATA: begin
        if (ovf) begin
          s_next.rx_ovf = s_reg.rx_ovf + 2'd1;
          if (s_reg.rx_ovf == ucdb_pkg::OVF_PER_BIT - 2'd1) begin
            s_next.rx_ovf = '0;
            s_next.rx_sh = {rx_line, s_reg.rx_sh[8:1]}; // RULE13
            s_next.rx_idx = s_reg.rx_idx + 4'd1;
            if (s_reg.rx_idx == nbits - 4'd1) begin
              s_next.rx_ph = ucdb_pkg::UCDB_STOP;
            end
          end
        end
      end
      ucdb_pkg::UCDB_STOP: begin
        if (ovf) begin
          s_next.rx_ovf = s_reg.rx_ovf + 2'd1;
          if (s_reg.rx_ovf == ucdb_pkg::OVF_PER_BIT - 2'd1) begin
            s_next.rx_ovf = '0;
            s_next.rx_ph = ucdb_pkg::UCDB_IDLE;
            stop_v = nine ? s_reg.rx_sh[8] : rx_line; // RULE3
            if (s_reg.control[ucdb_pkg::BIT_REN] &&
                (!s_reg.control[ucdb_pkg::BIT_MCE] || stop_v)) begin // RULE1 RULE12
              if (!nine) begin
                s_next.rx_latch = s_reg.rx_sh[8:1];
              end else begin
                s_next.rx_latch = s_reg.rx_sh[7:0];
              end
              s_next.control[ucdb_pkg::BIT_RB8] = stop_v; // RULE3
              set_rx = 1'b1; // RULE6
            end
          end
        end
      end
      default: s_next.rx_ph = ucdb_pkg::UCDB_IDLE;
    endcase
    // Register writes; hardware sets win over software clears.
    if (sfr_wr) begin
      case (sfr_addr)
        ucdb_pkg::ADDR_CONTROL: begin
          s_next.control = sfr_wdata;
          s_next.control[ucdb_pkg::BIT_UNUSED] = 1'b1;
        end
        ucdb_pkg::ADDR_BAUD: s_next.baud = sfr_wdata[2:0];
        ucdb_pkg::ADDR_RELOAD: s_next.reload = sfr_wdata;
        default: ;
      endcase
    end
    if (set_tx) begin
      s_next.control[ucdb_pkg::BIT_TXDONE] = 1'b1; // RULE4 RULE5
    end
    if (set_rx) begin
      s_next.control[ucdb_pkg::BIT_RXDONE] = 1'b1; // RULE6
    end
    // Registered read data, valid the cycle after the read strobe.
    if (sfr_rd) begin
      case (sfr_addr)
        ucdb_pkg::ADDR_CONTROL: s_next.rdata = s_reg.control;
        ucdb_pkg::ADDR_DATA: s_next.rdata = s_reg.rx_latch; // RULE8
        ucdb_pkg::ADDR_BAUD: s_next.rdata = {5'b0_0000, s_reg.baud};
        ucdb_pkg::ADDR_RELOAD: s_next.rdata = s_reg.reload;
        default: s_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_reg <= '0;
      s_reg.control <= ucdb_pkg::CONTROL_RESET;
      s_reg.rx_latch <= ucdb_pkg::DATA_RESET;
      s_reg.reload <= ucdb_pkg::RELOAD_RESET;
      s_reg.baud <= ucdb_pkg::BAUD_RESET;
      s_reg.tx_out <= 1'b1;
      s_reg.tx_ph <= ucdb_pkg::UCDB_IDLE;
      s_reg.rx_ph <= ucdb_pkg::UCDB_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule

// file: sim/ucdb_uart_asserts.sv
// Port checker of the UART block, bound to its top module.
`timescale 1ns/1ps
module ucdb_uart_asserts (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Register port.
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata,
  // Interrupt, serial lines and buffer state.
  input wire logic serial_int_enable,
  input wire logic serial_int_req,
  input wire logic tx_line,
  input wire logic rx_line,
  input wire logic tx_ready
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Four clocks is the shortest bit the bench sets up; a faster reload would trip these.
  sequence s_low_bit; !tx_line [*4]; endsequence
  sequence s_high_bit; tx_line [*4]; endsequence
  a_low_bit: assert property ($fell(tx_line) |-> s_low_bit)
    else $error("low level shorter than a bit");
  a_high_bit: assert property ($rose(tx_line) |-> s_high_bit)
    else $error("high level shorter than a bit");
  a_int_off: assert property (!serial_int_enable |-> !serial_int_req)
    else $error("request while disabled");
  a_int_clear: assert property ($fell(serial_int_req) |->
    $fell(serial_int_enable) || $past(sfr_wr && sfr_addr == ucdb_pkg::ADDR_CONTROL))
    else $error("flag cleared without software");
  a_ready_fall: assert property ($fell(tx_ready) |->
    $past(sfr_wr && sfr_addr == ucdb_pkg::ADDR_DATA)) else $error("full without a write");
  a_rdata_hold: assert property (!$past(sfr_rd) |-> $stable(sfr_rdata))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (sfr_rd && sfr_addr < 8'h98 |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_fixed_one: assert property (sfr_rd && sfr_addr == ucdb_pkg::ADDR_CONTROL |=>
    sfr_rdata[ucdb_pkg::BIT_UNUSED]) else $error("unused control bit not one");
endmodule
bind ucdb_uart ucdb_uart_asserts i_asserts (.clk(clk), .reset_n(reset_n),
  .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd),
  .sfr_rdata(sfr_rdata), .serial_int_enable(serial_int_enable),
  .serial_int_req(serial_int_req), .tx_line(tx_line), .rx_line(rx_line), .tx_ready(tx_ready));

// file: sim/ucdb_peer.sv
// Behavioural serial peer that sends frames and collects the frames it hears.
`timescale 1ns/1ps
module ucdb_peer #(
  parameter int BIT = 4
) (
  // Clock.
  input wire logic clk,
  // Serial lines seen from the far side.
  input wire logic tx_line,
  output logic rx_line
);
  logic nine;
  logic [9:0] w;
  logic [9:0] got[$];
  initial begin
    nine = 1'b0;
    rx_line = 1'b1;
  end
  // The line is pulled high between frames, so a low stop must not linger.
  task automatic send(input logic [8:0] d, input logic stop);
    logic [10:0] f;
    f = nine ? {stop, d, 1'b0} : {1'b1, stop, d[7:0], 1'b0};
    for (int i = 0; i < 11; i++) begin
      rx_line = f[i];
      repeat (BIT) @(negedge clk);
    end
    rx_line = 1'b1;
  endtask
  // Sampling mid-bit on falling edges keeps clear of the edge that moves the line.
  always begin
    @(negedge tx_line);
    repeat (BIT / 2) @(negedge clk);
    w = 10'h000;
    for (int i = 0; i < (nine ? 10 : 9); i++) begin
      repeat (BIT) @(negedge clk);
      w[i] = tx_line;
    end
    got.push_back(w);
  end
endmodule

// file: sim/testbench.sv
// Self-checking bench of the UART block with a serial peer on its lines.
`timescale 1ns/1ps
module testbench;
  logic clk, reset_n, sfr_wr, sfr_rd, serial_int_enable, serial_int_req;
  logic tx_line, rx_line, tx_ready;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  int n_fail, compares, cyc, n, k;
  typedef struct {logic [7:0] cfg; logic [7:0] rel; int clks;} ucdb_row_t;
  ucdb_row_t rows [5] = '{'{8'h04, 8'h2B, 426}, '{8'h01, 8'hFE, 16}, '{8'h00, 8'hFE, 48},
    '{8'h02, 8'hFE, 192}, '{8'h04, 8'hFE, 4}};
  ucdb_uart i_dut (.clk(clk), .reset_n(reset_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .serial_int_enable(serial_int_enable), .serial_int_req(serial_int_req),
    .tx_line(tx_line), .rx_line(rx_line), .tx_ready(tx_ready));
  ucdb_peer #(.BIT(4)) i_peer (.clk(clk), .tx_line(tx_line), .rx_line(rx_line));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      complete_run();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
    @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    check(sfr_rdata, e);
    @(negedge clk);
  endtask
  task automatic complete_run();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {reset_n, sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = '0;
    serial_int_enable = 1'b1;
    repeat (5) @(negedge clk);
    reset_n = 1'b1;
    rd(ucdb_pkg::ADDR_CONTROL, 8'h40);
    rd(ucdb_pkg::ADDR_DATA, 8'h00);
    rd(8'h97, 8'h00);
    $display("reset test done");
    foreach (rows[r]) begin
      wr(ucdb_pkg::ADDR_BAUD, rows[r].cfg);
      wr(ucdb_pkg::ADDR_RELOAD, rows[r].rel);
      wr(ucdb_pkg::ADDR_DATA, 8'h01);
      k = 0;
      while (tx_line !== 1'b0 && k < 2000) begin
        @(negedge clk);
        k++;
      end
      n = 0;
      while (tx_line === 1'b0 && n < 1000) begin
        @(negedge clk);
        n++;
      end
      check(n, rows[r].clks);
      repeat (10 * rows[r].clks) @(negedge clk);
      rd(ucdb_pkg::ADDR_CONTROL, 8'h42);
      check(serial_int_req, 1'b1);
      wr(ucdb_pkg::ADDR_CONTROL, 8'h00);
      check(serial_int_req, 1'b0);
      $display("baud row %0d done", r);
    end
    i_peer.send(9'h05A, 1'b1);
    rd(ucdb_pkg::ADDR_CONTROL, 8'h40);
    wr(ucdb_pkg::ADDR_CONTROL, 8'h10);
    i_peer.send(9'h0A5, 1'b1);
    rd(ucdb_pkg::ADDR_DATA, 8'hA5);
    rd(ucdb_pkg::ADDR_CONTROL, 8'h55);
    check(serial_int_req, 1'b1);
    serial_int_enable = 1'b0;
    @(negedge clk);
    check(serial_int_req, 1'b0);
    serial_int_enable = 1'b1;
    $display("receive test done");
    wr(ucdb_pkg::ADDR_CONTROL, 8'hB0);
    i_peer.nine = 1'b1;
    i_peer.send(9'h077, 1'b1);
    check(serial_int_req, 1'b0);
    rd(ucdb_pkg::ADDR_DATA, 8'hA5);
    i_peer.send(9'h181, 1'b1);
    rd(ucdb_pkg::ADDR_DATA, 8'h81);
    rd(ucdb_pkg::ADDR_CONTROL, 8'hF5);
    wr(ucdb_pkg::ADDR_CONTROL, 8'h98);
    i_peer.got.delete();
    wr(ucdb_pkg::ADDR_DATA, 8'h3C);
    repeat (60) @(negedge clk);
    check(i_peer.got.size(), 1);
    check(i_peer.got[0], 10'h33C);
    rd(ucdb_pkg::ADDR_CONTROL, 8'hDA);
    $display("nine-bit test done");
    wr(ucdb_pkg::ADDR_CONTROL, 8'h00);
    i_peer.nine = 1'b0;
    i_peer.got.delete();
    n = 0;
    sfr_addr = ucdb_pkg::ADDR_DATA;
    while (tx_ready === 1'b1 && n < 12) begin
      sfr_wr = 1'b1;
      sfr_wdata = 8'h10 + 8'(n);
      @(negedge clk);
      n++;
    end
    sfr_wr = 1'b0;
    @(negedge clk);
    check(tx_ready, 1'b0);
    check(n >= 8, 1'b1);
    wr(ucdb_pkg::ADDR_DATA, 8'hEE);
    k = 0;
    while (i_peer.got.size() < n && k < 2000) begin
      @(negedge clk);
      k++;
    end
    repeat (80) @(negedge clk);
    check(i_peer.got.size(), n);
    foreach (i_peer.got[j]) check(i_peer.got[j][7:0], 8'h10 + j);
    $display("buffer test done");
    complete_run();
  end
endmodule
